// ==== asf_defs.svh ====
// Purpose: Constants of the serial frame and state control block
// Assumes: 32-bit words, byte offsets on the register bus
// Notes:   Included by name; definitions only
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// -------------------------------------------------------------
// Frame
// -------------------------------------------------------------
`define ASF_WORD_W      32
`define ASF_CNT_W       6
`define ASF_CNT_MAX     6'h3f
`define ASF_FRAME_BITS  6'h20
`define ASF_NOP_CMD     32'h0000_0000

// -------------------------------------------------------------
// Register map, byte offsets
// -------------------------------------------------------------
`define ASF_ADDR_W      8
`define ASF_OFF_CTRL    8'h00
`define ASF_OFF_OUTCTL  8'h04
`define ASF_OFF_DATA    8'h08
`define ASF_OFF_STATUS  8'h0c
`define ASF_OFF_CMD     8'h10
`define ASF_CTRL_APP    0
`define ASF_OUTCTL_W    8
`define ASF_SAMP_W      16

// -------------------------------------------------------------
// Timing, ns
// -------------------------------------------------------------
`define ASF_CLK_NS      8
`define ASF_RST_LOW_NS  100
`define ASF_REC_POR_NS  20000
`define ASF_REC_APP_NS  1000
`define ASF_CONV_NS     800

`endif

// ==== asf_pkg.sv ====
// Purpose: Types of the serial frame and state control block
// Assumes: asf_defs.svh gives the widths
// Notes:   One packed struct holds the controller state; the command buffer keeps its own
`include "asf_defs.svh"

package asf_pkg;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_RECOV,
		ST_ACQ,
		ST_FRAME,
		ST_CONV
	} asf_state_e;

	typedef enum logic [1:0] {
		FK_NONE,
		FK_SHORT,
		FK_OPTIMAL,
		FK_LONG
	} asf_kind_e;

	typedef struct packed {
		logic cs;
		logic sclk;
	} asf_pins_s;

	typedef struct packed {
		asf_state_e                 state;
		asf_pins_s                  prev;
		logic [15:0]                rst_low;
		logic [31:0]                timer;
		logic                       por;
		logic [`ASF_WORD_W-1:0]     sr;
		logic                       out_bit;
		logic                       oe_n;
		logic                       rdy;
		logic [`ASF_CNT_W-1:0]      cnt;
		logic [`ASF_CNT_W-1:0]      last_cnt;
		asf_kind_e                  kind;
		logic [`ASF_WORD_W-1:0]     cmd;
		logic                       pend;
		logic [`ASF_SAMP_W-1:0]     samples;
		logic                       app_sel;
		logic [`ASF_OUTCTL_W-1:0]   out_ctl;
		logic [`ASF_WORD_W-1:0]     data_word;
		logic                       ack;
		logic [`ASF_WORD_W-1:0]     rdata;
	} asf_ctrl_s;

endpackage

// ==== asf_pair_buf.sv ====
// Purpose: Small buffer of command words with valid and ready
// Assumes: One clock, synchronous active-high reset
// Notes:   Read data come straight from the storage registers
`timescale 1ns/10ps
`default_nettype none

module asf_pair_buf #(
	parameter int W     = 32,
	parameter int DEPTH = 2
) (
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [PW:0]             cnt;
	} buf_s;

	buf_s q;
	buf_s n;
	logic push;
	logic pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("asf_pair_buf: DEPTH must be a power of two, two or more");
	end

	// ---------------------------------------------------------
	// Storage and pointers
	// ---------------------------------------------------------
	assign in_ready_o  = (q.cnt != PW'(0) + (PW+1)'(DEPTH)) && !flush_i;
	assign out_valid_o = (q.cnt != '0);
	assign out_data_o  = q.mem[q.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop  = out_valid_o && out_ready_i;

	always_comb begin
		n = q;
		if (push) begin
			n.mem[q.wp] = in_data_i;
			n.wp = q.wp + PW'(1);
		end
		if (pop) begin
			n.rp = q.rp + PW'(1);
		end
		n.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
		if (flush_i) begin
			n.wp  = '0;
			n.rp  = '0;
			n.cnt = '0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

endmodule

`default_nettype wire

// ==== asf_frame_ctrl.sv ====
// Purpose: Serial frame control and reset/acquire/convert sequencing
// Assumes: Pins synchronous to mclk_i; capture on serial clock rise,
//          launch on its fall; one shift register serves both ways
// Notes:   Decoded command words queue in a small buffer for software
`timescale 1ns/10ps
`default_nettype none
`include "asf_defs.svh"

module asf_frame_ctrl
	import asf_pkg::*;
#(
	parameter int CLK_NS     = `ASF_CLK_NS,
	parameter int RST_LOW_NS = `ASF_RST_LOW_NS,
	parameter int REC_POR_NS = `ASF_REC_POR_NS,
	parameter int REC_APP_NS = `ASF_REC_APP_NS,
	parameter int CONV_NS    = `ASF_CONV_NS
) (
	input  wire logic                    mclk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    convert_start_select_i,
	input  wire logic                    sclk_i,
	input  wire logic                    serial_in_i,
	output logic                         serial_out_lane0_o,
	output logic                         serial_out_lane0_oe_n_o,
	output logic                         ready_strobe_o,
	input  wire logic [`ASF_ADDR_W-1:0]  avs_address_i,
	input  wire logic                    avs_read_i,
	input  wire logic                    avs_write_i,
	input  wire logic [`ASF_WORD_W-1:0]  avs_writedata_i,
	output logic [`ASF_WORD_W-1:0]       avs_readdata_o,
	output logic                         avs_waitrequest_o
);

	// ---------------------------------------------------------
	// Cycle counts
	// ---------------------------------------------------------
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RST_CYC  = cyc_up(RST_LOW_NS);
	localparam int POR_CYC  = cyc_up(REC_POR_NS);
	localparam int APP_CYC  = cyc_up(REC_APP_NS);
	localparam int CONV_CYC = cyc_up(CONV_NS);

	localparam logic [15:0] RST_LAST = 16'(RST_CYC - 1);
	localparam logic [31:0] POR_LD   = 32'(POR_CYC - 1);
	localparam logic [31:0] APP_LD   = 32'(APP_CYC - 1);
	localparam logic [31:0] CONV_LD  = 32'(CONV_CYC - 1);

	if (CLK_NS < 1 || RST_CYC > 65535) begin : g_chk
		$error("asf_frame_ctrl: clock period or reset width out of range");
	end

	// ---------------------------------------------------------
	// Reset value of the state
	// ---------------------------------------------------------
	function automatic asf_ctrl_s init_state();
		asf_ctrl_s s;
		s = '0;
		s.state = ST_RECOV;
		s.timer = POR_LD;
		s.oe_n  = 1'b1;
		s.cmd   = `ASF_NOP_CMD;
		return s;
	endfunction

	function automatic logic [`ASF_CNT_W-1:0] sat_inc(
		input logic [`ASF_CNT_W-1:0] v
	);
		return (v == `ASF_CNT_MAX) ? v : v + `ASF_CNT_W'(1);
	endfunction

	asf_ctrl_s                q;
	asf_ctrl_s                n;
	logic                     req;
	logic                     cs_rise;
	logic                     cs_fall;
	logic                     cap;
	logic                     launch;
	logic                     rst_hit;
	logic                     push_ready;
	logic                     cmd_valid;
	logic [`ASF_WORD_W-1:0]   cmd_head;
	logic                     pop;
	logic                     flush;

	// ---------------------------------------------------------
	// Command word buffer
	// ---------------------------------------------------------
	asf_pair_buf #(
		.W     (`ASF_WORD_W),
		.DEPTH (2)
	) u_buf (
		.mclk_i      (mclk_i),
		.sys_rst_i   (sys_rst_i),
		.flush_i     (flush),
		.in_valid_i  (q.pend),
		.in_ready_o  (push_ready),
		.in_data_i   (q.cmd),
		.out_valid_o (cmd_valid),
		.out_ready_i (pop),
		.out_data_o  (cmd_head)
	);

	// ---------------------------------------------------------
	// Pin edges and bus handshake
	// ---------------------------------------------------------
	assign req     = avs_read_i || avs_write_i;
	assign cs_rise = convert_start_select_i && !q.prev.cs;
	assign cs_fall = !convert_start_select_i && q.prev.cs;
	assign cap     = sclk_i && !q.prev.sclk;
	assign launch  = !sclk_i && q.prev.sclk;
	assign rst_hit = !reset_n_i && (q.rst_low >= RST_LAST);
	assign pop     = avs_read_i && !q.ack
		&& (avs_address_i == `ASF_OFF_CMD) && cmd_valid;
	assign flush   = rst_hit && !q.app_sel && (q.state != ST_RESET);

	assign avs_waitrequest_o       = req && !q.ack;
	assign avs_readdata_o          = q.rdata;
	assign serial_out_lane0_o      = q.out_bit;
	assign serial_out_lane0_oe_n_o = q.oe_n;
	assign ready_strobe_o          = q.rdy;

	// ---------------------------------------------------------
	// Next state
	// ---------------------------------------------------------
	always_comb begin
		n = q;
		n.prev.cs   = convert_start_select_i;
		n.prev.sclk = sclk_i;
		n.ack       = req && !q.ack;

		// Register reads
		if (avs_read_i && !q.ack) begin
			case (avs_address_i)
				`ASF_OFF_CTRL: begin
					n.rdata = {31'h0000_0000, q.app_sel};
				end
				`ASF_OFF_OUTCTL: begin
					n.rdata = {24'h00_0000, q.out_ctl};
				end
				`ASF_OFF_DATA: begin
					n.rdata = q.data_word;
				end
				`ASF_OFF_STATUS: begin
					n.rdata = {q.samples, 2'h0, q.last_cnt,
						cmd_valid, q.pend, q.kind, q.rdy, q.state};
				end
				`ASF_OFF_CMD: begin
					n.rdata = cmd_valid ? cmd_head : `ASF_NOP_CMD;
				end
				default: begin
					n.rdata = '0;
				end
			endcase
		end

		// Register writes
		if (avs_write_i && q.ack) begin
			case (avs_address_i)
				`ASF_OFF_CTRL: begin
					n.app_sel = avs_writedata_i[`ASF_CTRL_APP];
				end
				`ASF_OFF_OUTCTL: begin
					n.out_ctl = avs_writedata_i[`ASF_OUTCTL_W-1:0];
				end
				`ASF_OFF_DATA: begin
					n.data_word = avs_writedata_i;
				end
				default: begin
				end
			endcase
		end

		// Reset pin low-time count
		if (reset_n_i) begin
			n.rst_low = '0;
		end else if (!rst_hit) begin
			n.rst_low = q.rst_low + 16'h0001;
		end

		// Decoded command handed to the buffer
		if (q.pend && push_ready) begin
			n.pend = 1'b0;
		end

		if (q.timer != '0) begin
			n.timer = q.timer - 32'h0000_0001;
		end

		case (q.state)
			ST_RESET: begin
				n.rdy  = 1'b0;
				n.oe_n = 1'b1;
				if (reset_n_i && !convert_start_select_i && !sclk_i) begin
					n.state = ST_RECOV;
					n.timer = q.por ? POR_LD : APP_LD;
				end
			end
			ST_RECOV: begin
				if (q.timer == '0) begin
					n.state = ST_ACQ;
					n.rdy   = 1'b1;
				end
			end
			ST_ACQ: begin
				if (cs_fall) begin
					n.state   = ST_FRAME;
					n.rdy     = 1'b0;
					n.cnt     = '0;
					n.sr      = q.data_word;
					n.out_bit = q.data_word[`ASF_WORD_W-1];
					n.oe_n    = 1'b0;
					n.cmd     = `ASF_NOP_CMD;
				end else if (cs_rise) begin
					n.state    = ST_CONV;
					n.rdy      = 1'b0;
					n.timer    = CONV_LD;
					n.kind     = FK_SHORT;
					n.last_cnt = '0;
					n.samples  = q.samples + `ASF_SAMP_W'(1);
				end
			end
			ST_FRAME: begin
				if (cap) begin
					n.cnt = sat_inc(q.cnt);
					n.sr  = {q.sr[`ASF_WORD_W-2:0], serial_in_i};
				end
				if (launch) begin
					n.out_bit = q.sr[`ASF_WORD_W-1];
				end
				if (cs_rise) begin
					n.state    = ST_CONV;
					n.oe_n     = 1'b1;
					n.rdy      = 1'b0;
					n.timer    = CONV_LD;
					n.last_cnt = q.cnt;
					n.samples  = q.samples + `ASF_SAMP_W'(1);
					if (q.cnt < `ASF_FRAME_BITS) begin
						n.kind = FK_SHORT;
					end else begin
						n.kind = (q.cnt == `ASF_FRAME_BITS)
							? FK_OPTIMAL : FK_LONG;
						n.cmd  = q.sr;
						n.pend = 1'b1;
					end
				end
			end
			ST_CONV: begin
				// Select edges have no effect here
				if (q.timer == '0 && !q.pend) begin
					n.state = ST_ACQ;
					n.rdy   = 1'b1;
				end
			end
			default: begin
				n.state = ST_RESET;
			end
		endcase

		// Reset pin overrides every state
		if (rst_hit && q.state != ST_RESET) begin
			n.state     = ST_RESET;
			n.rdy       = 1'b0;
			n.oe_n      = 1'b1;
			n.por       = !q.app_sel;
			n.app_sel   = 1'b0;
			n.out_ctl   = '0;
			n.data_word = '0;
			if (!q.app_sel) begin
				n.sr       = '0;
				n.out_bit  = 1'b0;
				n.cnt      = '0;
				n.last_cnt = '0;
				n.kind     = FK_NONE;
				n.cmd      = `ASF_NOP_CMD;
				n.pend     = 1'b0;
				n.samples  = '0;
				n.timer    = '0;
			end
		end else if (q.state == ST_RESET) begin
			n.sr  = q.sr;
			n.cnt = q.cnt;
		end
	end

	// ---------------------------------------------------------
	// State register
	// ---------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= init_state();
		end else begin
			q <= n;
		end
	end

endmodule

`default_nettype wire

// ==== asf_frame_ctrl_asserts.sv ====
// Purpose: Port assertions of the frame controller
// Assumes: Conversion lasts at least 8 cycles
// Notes:   Bound into asf_frame_ctrl
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Checker
// ------------------------------
module asf_frame_ctrl_asserts (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic reset_n_i,
	input wire logic convert_start_select_i,
	input wire logic sclk_i,
	input wire logic serial_out_lane0_o,
	input wire logic serial_out_lane0_oe_n_o,
	input wire logic ready_strobe_o,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_frame_start: assert property (
		$fell(convert_start_select_i) && ready_strobe_o && reset_n_i
		|-> ##[1:2] (!ready_strobe_o && !serial_out_lane0_oe_n_o))
		else $error("frame start not seen");
	a_frame_end: assert property (
		$rose(convert_start_select_i) && !serial_out_lane0_oe_n_o
		&& reset_n_i |-> ##[1:2] serial_out_lane0_oe_n_o)
		else $error("output not released");
	a_conv_quiet: assert property (
		$rose(convert_start_select_i) && !serial_out_lane0_oe_n_o
		&& reset_n_i |=> !ready_strobe_o [*8])
		else $error("ready during conversion");
	a_rst_enter: assert property (
		!reset_n_i [*4] |-> !ready_strobe_o && serial_out_lane0_oe_n_o)
		else $error("reset not entered");
	a_rst_quiet: assert property (
		!reset_n_i [*5] |-> $stable(serial_out_lane0_o))
		else $error("output moved in reset");
	a_recov_wait: assert property (
		$rose(reset_n_i) && !$past(reset_n_i, 2) && !ready_strobe_o
		|-> !ready_strobe_o [*4])
		else $error("ready before recovery");
	a_out_launch: assert property (
		!serial_out_lane0_oe_n_o && $past(!serial_out_lane0_oe_n_o)
		&& $changed(serial_out_lane0_o) |-> !sclk_i)
		else $error("output moved off launch");
	a_bus_wait: assert property (
		$rose(avs_read_i || avs_write_i)
		|-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("bus wait not one cycle");
endmodule

bind asf_frame_ctrl asf_frame_ctrl_asserts i_chk (
	.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i),
	.reset_n_i(reset_n_i),
	.convert_start_select_i(convert_start_select_i),
	.sclk_i(sclk_i),
	.serial_out_lane0_o(serial_out_lane0_o),
	.serial_out_lane0_oe_n_o(serial_out_lane0_oe_n_o),
	.ready_strobe_o(ready_strobe_o),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_waitrequest_o(avs_waitrequest_o)
);
`default_nettype wire

// ==== asf_host_model.sv ====
// Purpose: Host model driving select, serial clock and reset pin
// Assumes: Capture on clock rise, launch on fall
// Notes:   Each clock level held two cycles or more in frame; pin_reset toggles it every cycle when toggle is set, else holds it low
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Host
// ------------------------------
module asf_host_model (
	input  wire logic mclk_i,
	input  wire logic ready_strobe_i,
	input  wire logic serial_out_i,
	output logic      reset_n_o,
	output logic      select_o,
	output logic      sclk_o,
	output logic      serial_in_o
);
	initial begin
		reset_n_o = 1'b1;
		select_o = 1'b1;
		sclk_o = 1'b0;
		serial_in_o = 1'b0;
	end
	task automatic wait_ready;
		while (ready_strobe_i !== 1'b1)
			@(posedge mclk_i);
	endtask
	task automatic frame(input logic [63:0] tx, input int n,
		output logic [63:0] rx);
		wait_ready();
		rx = 64'h0000_0000_0000_0000;
		@(posedge mclk_i);
		select_o <= 1'b0;
		repeat (3) @(posedge mclk_i);
		for (int i = n - 1; i >= 0; i--) begin
			serial_in_o <= tx[i];
			repeat (2) @(posedge mclk_i);
			rx = {rx[62:0], serial_out_i};
			sclk_o <= 1'b1;
			repeat (2) @(posedge mclk_i);
			sclk_o <= 1'b0;
			repeat (3) @(posedge mclk_i);
		end
		select_o <= 1'b1;
		serial_in_o <= ~serial_in_o;
	endtask
	task automatic glitch;
		@(posedge mclk_i);
		select_o <= 1'b0;
		repeat (3) @(posedge mclk_i);
		select_o <= 1'b1;
	endtask
	task automatic pin_blip;
		@(posedge mclk_i);
		reset_n_o <= 1'b0;
		@(posedge mclk_i);
		reset_n_o <= 1'b1;
	endtask
	task automatic pin_reset(input logic toggle);
		wait_ready();
		@(posedge mclk_i);
		reset_n_o <= 1'b0;
		repeat (3) @(posedge mclk_i);
		select_o <= 1'b0;
		repeat (8) begin
			@(posedge mclk_i);
			sclk_o <= toggle & ~sclk_o;
			serial_in_o <= ~serial_in_o;
		end
		sclk_o <= 1'b0;
		repeat (2) @(posedge mclk_i);
		reset_n_o <= 1'b1;
		wait_ready();
		@(posedge mclk_i);
		select_o <= 1'b1;
		repeat (3) @(posedge mclk_i);
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench of the frame controller
// Assumes: Shortened timing parameters
// Notes:   Host model drives the serial pins
`timescale 1ns/10ps
`default_nettype none
`include "asf_defs.svh"
// ------------------------------
// Bench
// ------------------------------
module tb_top;
	localparam logic [31:0] ZW = 32'h0000_0000;
	logic        clk, rst, rd, wr, ws, rdy, oe_n, sdo, lane;
	logic        rst_n, sel, sclk, serial_in;
	logic [7:0]  adr;
	logic [31:0] wd, rdat, q, dw, cw, seed;
	logic [31:0] cq [3];
	logic [63:0] rx;
	int          err_total, n_checks, n;

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	assign lane = oe_n ? ~sdo : sdo;

	asf_frame_ctrl #(.RST_LOW_NS(16), .REC_POR_NS(80),
		.CONV_NS(80)) i_asf_frame_ctrl (
		.mclk_i(clk), .sys_rst_i(rst), .reset_n_i(rst_n),
		.convert_start_select_i(sel), .sclk_i(sclk), .serial_in_i(serial_in),
		.serial_out_lane0_o(sdo), .serial_out_lane0_oe_n_o(oe_n),
		.ready_strobe_o(rdy), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
		.avs_waitrequest_o(ws));
	asf_host_model i_asf_host_model (.mclk_i(clk), .ready_strobe_i(rdy),
		.serial_out_i(lane), .reset_n_o(rst_n), .select_o(sel),
		.sclk_o(sclk), .serial_in_o(serial_in));

	// ------------------------------
	// Helpers
	// ------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] exp_stat(input int n);
		logic [1:0] kind;
		kind = (n < 32) ? 2'h1 : (n == 32) ? 2'h2 : 2'h3;
		return {18'h0_0000, 6'(n), n >= 32, 1'b0, kind, 1'b1, 3'h2};
	endfunction
	task automatic chk_bit(input logic g, input logic e);
		chk({31'h0000_0000, g}, {31'h0000_0000, e});
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		adr <= a;
		wd <= d;
		do
			@(posedge clk);
		while (ws !== 1'b0);
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		end_sim();
	end

	// ------------------------------
	// Scenarios
	// ------------------------------
	initial begin
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		adr = 8'h00;
		wd = ZW;
		seed = 32'h0000_6d81;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		i_asf_host_model.wait_ready();
		chk_bit(rdy, 1'b1);
		bus(1'b1, `ASF_OFF_OUTCTL, ZW, q);
		bus(1'b0, 8'h14, ZW, q);
		chk(q, ZW);
		for (int k = 0; k < 3; k++) begin
			n = (k == 0) ? 32 : (k == 1) ? 16 : 40;
			dw = xs(seed);
			cw = xs(dw);
			seed = xs(cw);
			bus(1'b1, `ASF_OFF_DATA, dw, q);
			bus(1'b0, `ASF_OFF_DATA, ZW, q);
			chk(q, dw);
			i_asf_host_model.frame({seed, cw}, n, rx);
			q = (n < 32) ? rx[31:0] : rx[n-1 -: 32];
			chk(q, (n < 32) ? dw >> (32 - n) : dw);
			repeat (3) @(posedge clk);
			chk_bit(oe_n, 1'b1);
			i_asf_host_model.wait_ready();
			bus(1'b0, `ASF_OFF_STATUS, ZW, q);
			chk(32'(q[13:0]), exp_stat(n));
			bus(1'b0, `ASF_OFF_CMD, ZW, q);
			chk(q, n < 32 ? ZW : cw);
		end
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed);
			cq[k] = seed;
			i_asf_host_model.frame({ZW, seed}, 32, rx);
		end
		repeat (40) @(posedge clk);
		chk_bit(rdy, 1'b0);
		i_asf_host_model.glitch();
		repeat (3) @(posedge clk);
		chk_bit(rdy, 1'b0);
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, `ASF_OFF_CMD, ZW, q);
			chk(q, k < 3 ? cq[k] : ZW);
		end
		i_asf_host_model.wait_ready();
		chk_bit(oe_n, 1'b1);
		bus(1'b1, `ASF_OFF_CTRL, 32'h0000_0001, q);
		bus(1'b1, `ASF_OFF_DATA, seed, q);
		i_asf_host_model.pin_blip();
		repeat (3) @(posedge clk);
		chk_bit(rdy, 1'b1);
		bus(1'b0, `ASF_OFF_CTRL, ZW, q);
		chk(q, 32'h0000_0001);
		i_asf_host_model.pin_reset(1'b1);
		i_asf_host_model.wait_ready();
		bus(1'b0, `ASF_OFF_CTRL, ZW, q);
		chk(q, ZW);
		i_asf_host_model.frame({ZW, seed}, 32, rx);
		chk(rx[31:0], ZW);
		i_asf_host_model.pin_reset(1'b0);
		i_asf_host_model.wait_ready();
		bus(1'b0, `ASF_OFF_CMD, ZW, q);
		chk(q, ZW);
		end_sim();
	end
endmodule
`default_nettype wire
